// [pkg/sps_pkg.sv]
// constants and types shared by the sequential positioning sequencer
//
// Operation
// - each sequential start runs the next entry
// - chain returns to origin before disabled-flag entry
// - select or direct inputs move the sequence origin
// - with no origin, first run is entry 0
// - entry started by select becomes new origin
// - READY drops at motion start; host then releases
// - READY returns when the motion finishes
// - clearing sets origin 0, current entry -1
// - power-up is a clearing event
// - non-positioning operation clears the sequence
// - alarm raised then reset clears the sequence
// - stop input clears the sequence
// - de-energizing input clears the sequence
// - preset or configuration command clears the sequence
// - start runs entry chosen by six select bits
// - direct inputs run their assigned entry numbers
// - each entry holds sequential flag, default disabled
package sps_pkg;

  // table geometry
  localparam int SPS_ENTRY_W = 6;
  localparam int SPS_ENTRIES = 64;
  localparam int SPS_DIRECT_N = 6;
  localparam int SPS_CUR_W = 7;

  // current-entry value meaning "none run yet"
  localparam logic [6:0] SPS_CUR_NONE = 7'h7F;
  localparam logic [5:0] SPS_ORIGIN_RST = 6'h00;
  localparam logic [5:0] SPS_ENTRY_LAST = 6'h3F;

  // register byte addresses
  localparam logic [7:0] SPS_ADDR_FLAG_LO = 8'h00;
  localparam logic [7:0] SPS_ADDR_FLAG_HI = 8'h04;
  localparam logic [7:0] SPS_ADDR_MAP_A = 8'h08;
  localparam logic [7:0] SPS_ADDR_MAP_B = 8'h0C;
  localparam logic [7:0] SPS_ADDR_STATUS = 8'h10;

  // field positions
  localparam int SPS_MAP_STRIDE = 8;
  localparam int SPS_ST_CUR_LSB = 0;
  localparam int SPS_ST_ORG_LSB = 8;
  localparam int SPS_ST_READY_BIT = 16;
  localparam int SPS_ST_LAST_LSB = 24;

  // reset values: flags disabled, direct map 0..5
  localparam logic [31:0] SPS_FLAG_RST = 32'h0000_0000;
  localparam logic [31:0] SPS_MAP_A_RST = 32'h0302_0100;
  localparam logic [31:0] SPS_MAP_B_RST = 32'h0000_0504;

  // sequencer states
  typedef enum logic [0:0] {
    SPS_IDLE,
    SPS_MOVING
  } sps_state_e;

endpackage : sps_pkg

// [hdl/sps_input_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
module sps_input_sync #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // asynchronous pins in
  input wire logic [WIDTH-1:0] pinIn,
  // filtered, clocked levels out
  output logic [WIDTH-1:0] levelOut
);

  // stage one is read only by stage two
  logic [WIDTH-1:0] stg1_r;
  logic [WIDTH-1:0] stg2_r;
  logic [WIDTH-1:0] stg3_r;
  logic [WIDTH-1:0] level_r;
  // bits where the two settled stages agree
  wire [WIDTH-1:0] agree = ~(stg2_r ^ stg3_r);
  wire [WIDTH-1:0] level_nxt = (agree & stg3_r) | (~agree & level_r);

  // shift chain and filtered level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stg1_r <= '0;
      stg2_r <= '0;
      stg3_r <= '0;
      level_r <= '0;
    end else begin
      stg1_r <= pinIn;
      stg2_r <= stg1_r;
      stg3_r <= stg2_r;
      level_r <= level_nxt;
    end
  end

  assign levelOut = level_r;

endmodule : sps_input_sync

// [hdl/sps_sequencer.sv]
// sequential positioning sequencer: entry chaining, origin, READY
//
// The plain strobed port and the address map were decided locally.
module sps_sequencer
  import sps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // host pins, asynchronous
  input wire logic seq_advance_input,
  input wire logic startIn,
  input wire logic [5:0] entry_select_inputs,
  input wire logic [5:0] direct_launch_inputs,
  input wire logic stopIn,
  input wire logic freeRunIn,
  input wire logic excitationOffIn,
  // driver-internal events, same clock
  input wire logic alarmActive,
  input wire logic nonPosOpStart,
  input wire logic presetCmd,
  input wire logic configCmd,
  // motion engine handshake
  input wire logic motionDone,
  output logic motionStart,
  output logic [5:0] motionEntry,
  // host status pin
  output logic readyOut
);

  ////////////////////////////////////////////////////////////////////
  // helper functions
  ////////////////////////////////////////////////////////////////////

  // pick the six-bit map field for one direct input
  function automatic logic [5:0] mapField(
    input logic [31:0] mapA,
    input logic [31:0] mapB,
    input logic [2:0] idx
  );
    logic [63:0] both;
    both = {mapB, mapA};
    mapField = both[idx*SPS_MAP_STRIDE +: SPS_ENTRY_W];
  endfunction : mapField

  // lowest-numbered active direct input
  function automatic logic [2:0] firstSet(
    input logic [5:0] bits
  );
    logic [2:0] pos;
    pos = 3'h0;
    for (int i = SPS_DIRECT_N - 1; i >= 0; i--) begin
      if (bits[i]) begin
        pos = 3'(i);
      end
    end
    firstSet = pos;
  endfunction : firstSet

  // rising edge of a clocked level
  function automatic logic [5:0] rise6(
    input logic [5:0] now,
    input logic [5:0] was
  );
    rise6 = now & ~was;
  endfunction : rise6

  ////////////////////////////////////////////////////////////////////
  // input synchronisation
  ////////////////////////////////////////////////////////////////////

  // all pin levels after the agreement filter
  logic [16:0] pinSync;

  // one shared chain keeps the pins aligned to each other
  sps_input_sync #(
    .WIDTH(17)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pinIn({excitationOffIn, freeRunIn, stopIn, direct_launch_inputs,
            entry_select_inputs, startIn, seq_advance_input}),
    .levelOut(pinSync)
  );

  // unpacked synchronised levels
  wire seqLvl = pinSync[0];
  wire startLvl = pinSync[1];
  wire [5:0] selLvl = pinSync[7:2];
  wire [5:0] directLvl = pinSync[13:8];
  wire stopLvl = pinSync[14];
  wire freeLvl = pinSync[15];
  wire excOffLvl = pinSync[16];

  // previous levels for edge detection
  logic seqPrev_r;
  logic startPrev_r;
  logic [5:0] directPrev_r;
  logic alarmPrev_r;

  // history of levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seqPrev_r <= 1'b0;
      startPrev_r <= 1'b0;
      directPrev_r <= 6'h00;
      alarmPrev_r <= 1'b0;
    end else begin
      seqPrev_r <= seqLvl;
      startPrev_r <= startLvl;
      directPrev_r <= directLvl;
      alarmPrev_r <= alarmActive;
    end
  end

  // edges of host commands
  wire seqEdge = seqLvl & ~seqPrev_r;
  wire startEdge = startLvl & ~startPrev_r;
  wire [5:0] directEdge = rise6(directLvl, directPrev_r);
  wire directAny = |directEdge;
  // alarm reset is seen as the alarm falling away
  wire alarmCleared = alarmPrev_r & ~alarmActive;

  ////////////////////////////////////////////////////////////////////
  // register file
  ////////////////////////////////////////////////////////////////////

  // per-entry sequential flags, split in two words
  logic [31:0] flagLo_r;
  logic [31:0] flagHi_r;
  // direct-input entry assignment
  logic [31:0] mapA_r;
  logic [31:0] mapB_r;
  // read answer register
  logic [31:0] rdData_r;

  // address decode
  wire hitFlagLo = (regAddr == SPS_ADDR_FLAG_LO);
  wire hitFlagHi = (regAddr == SPS_ADDR_FLAG_HI);
  wire hitMapA = (regAddr == SPS_ADDR_MAP_A);
  wire hitMapB = (regAddr == SPS_ADDR_MAP_B);
  wire hitStatus = (regAddr == SPS_ADDR_STATUS);

  // only the six-bit fields of each map byte are kept
  wire [31:0] mapMaskA = 32'h3F3F_3F3F;
  wire [31:0] mapMaskB = 32'h0000_3F3F;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flagLo_r <= SPS_FLAG_RST;
      flagHi_r <= SPS_FLAG_RST;
    end else if (regWrEn) begin
      if (hitFlagLo) begin
        flagLo_r <= regWrData;
      end
      if (hitFlagHi) begin
        flagHi_r <= regWrData;
      end
    end
  end

  // direct map storage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mapA_r <= SPS_MAP_A_RST;
      mapB_r <= SPS_MAP_B_RST;
    end else if (regWrEn) begin
      if (hitMapA) begin
        mapA_r <= regWrData & mapMaskA;
      end
      if (hitMapB) begin
        mapB_r <= regWrData & mapMaskB;
      end
    end
  end

  // all 64 flags as one vector
  wire [63:0] seqFlags = {flagHi_r, flagLo_r};

  ////////////////////////////////////////////////////////////////////
  // sequence state
  ////////////////////////////////////////////////////////////////////

  // sequence origin and most recent entry (-1 = none)
  logic [5:0] origin_r;
  logic [5:0] origin_nxt;
  logic [6:0] cur_r;
  logic [6:0] cur_nxt;
  // controller state
  sps_state_e state_r;
  sps_state_e state_nxt;
  // launch outputs
  logic launch_r;
  logic launch_nxt;
  logic [5:0] entry_r;
  logic [5:0] entry_nxt;

  wire levelClear = stopLvl | freeLvl | excOffLvl;
  wire pulseClear = nonPosOpStart | alarmCleared | presetCmd | configCmd;
  wire seqClear = levelClear | pulseClear;

  // chain stops before an entry whose flag is disabled
  wire curNone = (cur_r == SPS_CUR_NONE);
  wire [5:0] curPlus = cur_r[5:0] + 6'h01;
  wire nextFlag = seqFlags[curPlus];
  // the last entry never links past the end of the table
  wire curLast = (cur_r[5:0] == SPS_ENTRY_LAST);
  wire [5:0] seqNext = (curNone | ~nextFlag | curLast) ? origin_r : curPlus;

  // entry assigned to the first direct input that rose
  wire [5:0] directEntry = mapField(mapA_r, mapB_r, firstSet(directEdge));

  // launches are only taken while idle and not clearing
  wire canLaunch = (state_r == SPS_IDLE) & ~seqClear;

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    origin_nxt = origin_r;
    cur_nxt = cur_r;
    launch_nxt = 1'b0;
    entry_nxt = entry_r;
    case (state_r)
      // waiting for a command
      SPS_IDLE: begin
        if (canLaunch & startEdge) begin
          origin_nxt = selLvl;
          cur_nxt = {1'b0, selLvl};
          entry_nxt = selLvl;
          launch_nxt = 1'b1;
          state_nxt = SPS_MOVING;
        end else if (canLaunch & directAny) begin
          origin_nxt = directEntry;
          cur_nxt = {1'b0, directEntry};
          entry_nxt = directEntry;
          launch_nxt = 1'b1;
          state_nxt = SPS_MOVING;
        end else if (canLaunch & seqEdge) begin
          cur_nxt = {1'b0, seqNext};
          entry_nxt = seqNext;
          launch_nxt = 1'b1;
          state_nxt = SPS_MOVING;
        end
      end
      // motion running, READY low
      SPS_MOVING: begin
        // edges seen here are dropped, not queued
        if (motionDone) begin
          state_nxt = SPS_IDLE;
        end
      end
      default: begin
        state_nxt = SPS_IDLE;
      end
    endcase
    if (seqClear) begin
      origin_nxt = SPS_ORIGIN_RST;
      cur_nxt = SPS_CUR_NONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      origin_r <= SPS_ORIGIN_RST;
      cur_r <= SPS_CUR_NONE;
    end else begin
      origin_r <= origin_nxt;
      cur_r <= cur_nxt;
    end
  end

  // state register drops READY on launch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= SPS_IDLE;
      launch_r <= 1'b0;
      entry_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      launch_r <= launch_nxt;
      entry_r <= entry_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path
  ////////////////////////////////////////////////////////////////////

  // status word: current entry, origin, ready, last launched
  wire readyNow = (state_r == SPS_IDLE);
  wire [31:0] statusWord = {2'b00, entry_r, 7'h00, readyNow,
                            2'b00, origin_r, 1'b0, cur_r};

  // read multiplexer; unmapped addresses answer zero
  wire [31:0] rdMux = hitFlagLo ? flagLo_r :
                      hitFlagHi ? flagHi_r :
                      hitMapA ? mapA_r :
                      hitMapB ? mapB_r :
                      hitStatus ? statusWord : 32'h0000_0000;

  // data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdData_r <= 32'h0000_0000;
    end else if (regRdEn) begin
      rdData_r <= rdMux;
    end else begin
      rdData_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////

  assign readyOut = readyNow;
  assign motionStart = launch_r;
  assign motionEntry = entry_r;
  assign regRdData = rdData_r;

endmodule : sps_sequencer

// [tb/sps_seq_monitor.sv]
// checker for launch, READY and read-port timing of the sequencer
module sps_seq_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // read port
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  // host pins and engine handshake
  input wire logic stopIn,
  input wire logic motionDone,
  input wire logic motionStart,
  input wire logic [5:0] motionEntry,
  input wire logic readyOut
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  a_launch_drops_ready: assert property (motionStart |-> !readyOut)
    else $error("launch without READY drop");
  a_launch_needs_ready: assert property (motionStart |-> $past(readyOut))
    else $error("launch while not ready");
  a_launch_single: assert property (motionStart |=> !motionStart)
    else $error("launch pulse too long");
  // reset sets READY, so a rise just after reset has no done cause
  a_ready_after_done: assert property ($rose(readyOut) && !$past(srst) |-> $past(motionDone))
    else $error("READY back without done");
  a_ready_waits_done: assert property (!readyOut && !motionDone |=> !readyOut)
    else $error("READY back early");
  a_ready_fall_cause: assert property ($fell(readyOut) |-> motionStart)
    else $error("READY fell without launch");
  a_entry_holds: assert property (!motionStart && !$past(srst) |-> $stable(motionEntry))
    else $error("entry changed without launch");
  a_stop_blocks_launch: assert property (stopIn [*8] |-> !motionStart)
    else $error("launch while stopped");
  a_read_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
    else $error("read data outside answer cycle");
endmodule : sps_seq_monitor

bind sps_sequencer sps_seq_monitor u_mon (.ref_clk, .srst, .regRdEn, .regRdData, .stopIn,
  .motionDone, .motionStart, .motionEntry, .readyOut);

// [tb/sps_motion_model.sv]
// motion engine stand-in: answers each launch with a done pulse
module sps_motion_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // handshake
  input wire logic motionStart,
  input wire logic [7:0] holdCycles,
  output logic motionDone = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  // done comes holdCycles+2 cycles after the launch cycle, prompt or slow
  always @(posedge ref_clk) begin
    motionDone <= !srst && !motionStart && cnt == 1;
    if (srst) begin
      cnt <= 0;
    end else if (motionStart) begin
      cnt <= holdCycles + 1;
    end else if (cnt == 1) begin
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : sps_motion_model

// [tb/tb.sv]
// self-checking bench for the sequential positioning sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic seqIn = 1'b0;
  logic startIn = 1'b0;
  logic [5:0] sel = 6'h00;
  logic [5:0] dir = 6'h00;
  // events: nonpos, preset, config, alarm, stop, free, exc-off
  logic [6:0] ev = 7'h00;
  logic [7:0] hold = 8'h00;
  logic motionDone;
  logic motionStart;
  logic [5:0] motionEntry;
  logic readyOut;
  int error_cnt = 0;
  int n_tests = 0;
  // reference model state
  int org = 0;
  int cur = -1;
  int dmap[6] = '{0, 1, 2, 3, 4, 5};
  bit [63:0] flg = 64'h0;
  int e;
  // launches seen on the engine handshake
  int nLaunch = 0;

  initial forever #12.5 ref_clk = ~ref_clk;

  // count every launch pulse the design issues
  always @(posedge ref_clk) begin
    if (motionStart === 1'b1) begin
      nLaunch <= nLaunch + 1;
    end
  end

  sps_sequencer DUT (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .seq_advance_input(seqIn),
    .startIn(startIn), .entry_select_inputs(sel), .direct_launch_inputs(dir), .stopIn(ev[4]),
    .freeRunIn(ev[5]), .excitationOffIn(ev[6]), .alarmActive(ev[3]), .nonPosOpStart(ev[0]),
    .presetCmd(ev[1]), .configCmd(ev[2]), .motionDone(motionDone), .motionStart(motionStart),
    .motionEntry(motionEntry), .readyOut(readyOut));
  sps_motion_model u_eng (.ref_clk(ref_clk), .srst(srst), .motionStart(motionStart),
    .holdCycles(hold), .motionDone(motionDone));

  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    chk("read", exp, regRdData & m);
  endtask : rd

  // status: current entry, origin, ready
  task automatic st();
    rd(8'h10, 32'h0001_3F7F, 32'h0001_0000 | (org << 8) | (cur < 0 ? 32'h7F : cur));
  endtask : st

  // bounded wait for READY to reach a level
  task automatic waitr(logic lvl);
    for (int i = 0; i < 60 && readyOut !== lvl; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (readyOut !== lvl) begin
      error_cnt++;
      conclude();
    end
  endtask : waitr

  // launch: 0 sequential, 1 select+start, 2 direct input v
  task automatic go(int k, int v);
    int x;
    int n0;
    if (k == 0) x = (cur < 0 || cur == 63 || !flg[cur + 1]) ? org : cur + 1;
    else x = (k == 1) ? v : dmap[v];
    waitr(1'b1);
    n0 = nLaunch;
    @(posedge ref_clk);
    hold <= 8'($urandom_range(0, 20));
    if (k == 0) seqIn <= 1'b1;
    else if (k == 1) startIn <= 1'b1;
    else dir <= 6'h01 << v;
    sel <= v[5:0];
    waitr(1'b0);
    chk("entry", x, {26'h0, motionEntry});
    @(posedge ref_clk);
    seqIn <= 1'b0;
    startIn <= 1'b0;
    dir <= 6'h00;
    cur = x;
    if (k > 0) org = x;
    waitr(1'b1);
    repeat (6) @(posedge ref_clk);
    chk("launches", 1, nLaunch - n0);
  endtask : go

  // a press while READY is low must be dropped, not queued
  task automatic busy();
    int n0;
    waitr(1'b1);
    n0 = nLaunch;
    @(posedge ref_clk);
    hold <= 8'h28;
    startIn <= 1'b1;
    sel <= 6'h0A;
    waitr(1'b0);
    @(posedge ref_clk);
    startIn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    seqIn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    seqIn <= 1'b0;
    waitr(1'b1);
    repeat (8) @(posedge ref_clk);
    chk("launches", 1, nLaunch - n0);
    org = 10;
    cur = 10;
  endtask : busy

  // fire one clearing event; level pins held long enough to be seen
  task automatic clr(int k);
    @(posedge ref_clk);
    ev <= 7'h01 << k;
    repeat (k < 3 ? 1 : 10) @(posedge ref_clk);
    ev <= 7'h00;
    repeat (6) @(posedge ref_clk);
    org = 0;
    cur = -1;
  endtask : clr

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(35));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    st();
    rd(8'h00, 32'hFFFF_FFFF, 32'h0);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0302_0100);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0);
    // chained entries carry an enabled flag
    wr(8'h00, 32'h0000_01BF);
    flg[31:0] = 32'h0000_01BF;
    for (int i = 0; i < 8; i++) go(0, 0);
    st();
    go(1, 7);
    for (int i = 0; i < 3; i++) go(0, 0);
    e = $urandom_range(10, 62);
    wr(8'h0C, {16'h0, 8'h05, 2'b00, e[5:0]});
    dmap[4] = e;
    flg[63:32] = $urandom;
    wr(8'h04, flg[63:32]);
    rd(8'h0C, 32'hFFFF_FFFF, {16'h0, 8'h05, 2'b00, e[5:0]});
    go(2, 4);
    go(0, 0);
    go(1, 63);
    go(0, 0);
    st();
    busy();
    st();
    for (int k = 0; k < 7; k++) begin
      go(1, 7);
      clr(k);
      st();
      go(0, 0);
    end
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    org = 0;
    cur = -1;
    st();
    rd(8'h04, 32'hFFFF_FFFF, 32'h0);
    conclude();
  end
endmodule : tb
